/* include/sro_pkg.sv */
// Package for the serial and converter signal routing option bank.
// Assumes a 32-bit APB slave port and combinational routing muxes downstream.
package sro_pkg;

    // Register byte offsets
    localparam logic [15:0] OPT5_OFFSET = 16'h1010;
    localparam logic [15:0] OPT7_OFFSET = 16'h1018;

    // Field positions, serial port routing options
    localparam int P2_ODE_BIT   = 18;
    localparam int P1_ODE_BIT   = 17;
    localparam int P0_ODE_BIT   = 16;
    localparam int P1_RX_BIT    = 6;
    localparam int P1_TX_LSB    = 4;
    localparam int P0_RX_BIT    = 2;
    localparam int P0_TX_LSB    = 0;

    // Field positions, converter trigger options
    localparam int ALT_EN_BIT   = 7;
    localparam int PRE_SEL_BIT  = 4;
    localparam int TRG_SEL_LSB  = 0;
    localparam int TRG_SEL_W    = 4;

    // Writable bits; all others read zero
    localparam logic [31:0] OPT5_WR_MASK = 32'h0007_0077;
    localparam logic [31:0] OPT7_WR_MASK = 32'h0000_009F;

    // Alternate converter trigger codes
    localparam logic [3:0] TRG_EXT       = 4'h0;
    localparam logic [3:0] TRG_ANALOG_COMPARATOR_0      = 4'h1;
    localparam logic [3:0] TRG_PIT0      = 4'h4;
    localparam logic [3:0] TRG_PIT1      = 4'h5;
    localparam logic [3:0] TRG_TMR0_OVF  = 4'h8;
    localparam logic [3:0] TRG_TMR1_OVF  = 4'h9;
    localparam logic [3:0] TRG_TMR2_OVF  = 4'hA;
    localparam logic [3:0] TRG_UNLISTED  = 4'hB;
    localparam logic [3:0] TRG_RTC_ALARM = 4'hC;
    localparam logic [3:0] TRG_RTC_SEC   = 4'hD;
    localparam logic [3:0] TRG_LPTMR     = 4'hE;

    typedef enum logic [1:0] {
        TX_PLAIN    = 2'h0,
        TX_TIMER_1  = 2'h1,
        TX_TIMER_2  = 2'h2,
        TX_RESERVED = 2'h3
    } sro_tx_src_t;

    typedef struct packed {
        logic        port2_open_drain_enable;
        logic        port1_open_drain_enable;
        logic        port0_open_drain_enable;
        logic        port1_receive_source;
        sro_tx_src_t port1_transmit_source;
        logic        port0_receive_source;
        sro_tx_src_t port0_transmit_source;
    } sro_opt5_t;

    typedef struct packed {
        logic       converter_alt_trigger_enable;
        logic       converter_pretrigger_select;
        logic [3:0] converter_trigger_select;
    } sro_opt7_t;

    typedef struct packed {
        logic ext;
        logic analog_comparator_0;
        logic pit0;
        logic pit1;
        logic tmr0_ovf;
        logic tmr1_ovf;
        logic tmr2_ovf;
        logic rtc_alarm;
        logic rtc_seconds;
        logic lptmr;
    } sro_trig_src_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } sro_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sro_apb_rsp_t;

    localparam sro_opt5_t OPT5_RESET = '0;
    localparam sro_opt7_t OPT7_RESET = '0;

endpackage : sro_pkg

/* rtl/sro_tx_mux.sv */
// Transmit source mux for one serial port.
// Assumes timer outputs and transmit data are levels in the clock domain.
`timescale 1ns/100ps
module sro_tx_mux (
    // Clock for checks
    input  wire logic              clock,
    input  wire logic              arst_n,
    // Selection
    input  wire sro_pkg::sro_tx_src_t sel,
    // Sources
    input  wire logic              tx_in,
    input  wire logic              timer_1_ch0,
    input  wire logic              timer_2_ch0,
    // Routed output
    output logic                   tx_out
);

    always_comb
    begin
        unique case (sel)
            sro_pkg::TX_PLAIN:    tx_out = tx_in;
            sro_pkg::TX_TIMER_1:  tx_out = tx_in & timer_1_ch0;
            sro_pkg::TX_TIMER_2:  tx_out = tx_in & timer_2_ch0;
            sro_pkg::TX_RESERVED: tx_out = tx_in;
        endcase
    end

    tx_timer1_a: assert property (@(posedge clock) disable iff (!arst_n)
        (sel == sro_pkg::TX_TIMER_1 && !timer_1_ch0) |-> !tx_out)
        else $error("transmit not gated by timer 1");

    tx_timer2_a: assert property (@(posedge clock) disable iff (!arst_n)
        (sel == sro_pkg::TX_TIMER_2) |-> (tx_out == (tx_in && timer_2_ch0)))
        else $error("transmit not gated by timer 2");

    tx_plain_a: assert property (@(posedge clock) disable iff (!arst_n)
        (sel == sro_pkg::TX_PLAIN) |-> (tx_out == tx_in))
        else $error("plain transmit path wrong");

endmodule : sro_tx_mux

/* rtl/sro_trig_mux.sv */
// Converter trigger and pre-trigger routing.
// Assumes trigger sources stay live in stop modes; no path here uses a clock.
`timescale 1ns/100ps
module sro_trig_mux (
    // Clock for checks
    input  wire logic                  clock,
    input  wire logic                  arst_n,
    // Selection
    input  wire sro_pkg::sro_opt7_t    opt,
    // Sources
    input  wire sro_pkg::sro_trig_src_t src,
    input  wire logic                  timer_1_ch0,
    input  wire logic                  timer_1_ch1,
    // Converter triggers A and B
    output logic                       conv_trig_a,
    output logic                       conv_trig_b
);

    function automatic logic pick(input logic [3:0] sel, input sro_pkg::sro_trig_src_t s);
        logic r;
        r = 1'b0;
        unique case (sel)
            sro_pkg::TRG_EXT:       r = s.ext;
            sro_pkg::TRG_ANALOG_COMPARATOR_0:      r = s.analog_comparator_0;
            sro_pkg::TRG_PIT0:      r = s.pit0;
            sro_pkg::TRG_PIT1:      r = s.pit1;
            sro_pkg::TRG_TMR0_OVF:  r = s.tmr0_ovf;
            sro_pkg::TRG_TMR1_OVF:  r = s.tmr1_ovf;
            sro_pkg::TRG_TMR2_OVF:  r = s.tmr2_ovf;
            sro_pkg::TRG_RTC_ALARM: r = s.rtc_alarm;
            sro_pkg::TRG_RTC_SEC:   r = s.rtc_seconds;
            sro_pkg::TRG_LPTMR:     r = s.lptmr;
            default:                r = 1'b0;
        endcase
        return r;
    endfunction : pick

    logic alt_trig;

    // Purely combinational so routing survives a stopped bus clock
    always_comb
    begin
        alt_trig = pick(opt.converter_trigger_select, src);
        if (opt.converter_alt_trigger_enable)
        begin
            conv_trig_a = alt_trig & ~opt.converter_pretrigger_select;
            conv_trig_b = alt_trig & opt.converter_pretrigger_select;
        end
        else
        begin
            conv_trig_a = timer_1_ch0;
            conv_trig_b = timer_1_ch1;
        end
    end

    default_trig_a: assert property (@(posedge clock) disable iff (!arst_n)
        !opt.converter_alt_trigger_enable |-> (conv_trig_a == timer_1_ch0 && conv_trig_b == timer_1_ch1))
        else $error("default timer triggers not routed");

    pretrig_b_a: assert property (@(posedge clock) disable iff (!arst_n)
        (opt.converter_alt_trigger_enable && opt.converter_pretrigger_select
         && opt.converter_trigger_select == sro_pkg::TRG_ANALOG_COMPARATOR_0) |-> (!conv_trig_a && conv_trig_b == src.analog_comparator_0))
        else $error("pre-trigger B routing wrong");

    trig_ext_a: assert property (@(posedge clock) disable iff (!arst_n)
        (opt.converter_alt_trigger_enable && !opt.converter_pretrigger_select
         && opt.converter_trigger_select == sro_pkg::TRG_EXT) |-> (conv_trig_a == src.ext && !conv_trig_b))
        else $error("external trigger routing wrong");

    trig_unlisted_a: assert property (@(posedge clock) disable iff (!arst_n)
        (opt.converter_alt_trigger_enable && opt.converter_trigger_select == sro_pkg::TRG_UNLISTED)
        |-> (!conv_trig_a && !conv_trig_b))
        else $error("unlisted trigger code produced a trigger");

endmodule : sro_trig_mux

/* rtl/sro_top.sv */
// Signal routing option bank: two APB registers steering serial, timer,
// comparator and converter muxes. Assumes a 32-bit APB4 master on clock.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
module sro_top (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   arst_n,
    // APB slave
    input  wire sro_pkg::sro_apb_req_t  apb_req,
    output sro_pkg::sro_apb_rsp_t       apb_rsp,
    // Open-drain enables to the serial ports
    output logic                        port0_open_drain_enable,
    output logic                        port1_open_drain_enable,
    output logic                        port2_open_drain_enable,
    // Receive routing
    input  wire logic                   port0_rx_pin,
    input  wire logic                   port1_rx_pin,
    output logic                        port0_rx_data,
    output logic                        port1_rx_data,
    // Transmit routing
    input  wire logic                   port0_tx_data,
    input  wire logic                   port1_tx_data,
    output logic                        port0_tx_pin,
    output logic                        port1_tx_pin,
    // Timer and comparator sources
    input  wire logic                   timer_1_ch0,
    input  wire logic                   timer_1_ch1,
    input  wire logic                   timer_2_ch0,
    input  wire logic                   analog_comparator_0_out,
    // Alternate converter trigger sources
    input  wire sro_pkg::sro_trig_src_t trig_src,
    // Converter triggers
    output logic                        conv_trig_a,
    output logic                        conv_trig_b
);

    sro_pkg::sro_opt5_t opt5_q;
    sro_pkg::sro_opt5_t opt5_d;
    sro_pkg::sro_opt7_t opt7_q;
    sro_pkg::sro_opt7_t opt7_d;
    logic [31:0]        prdata_q;
    logic [31:0]        prdata_d;
    logic               pslverr_q;
    logic               pslverr_d;

    logic               setup;
    logic               access;
    logic               hit5;
    logic               hit7;

    assign setup  = apb_req.psel && !apb_req.penable;
    assign access = apb_req.psel && apb_req.penable;
    assign hit5   = apb_req.paddr == sro_pkg::OPT5_OFFSET;
    assign hit7   = apb_req.paddr == sro_pkg::OPT7_OFFSET;

    function automatic logic [31:0] opt5_to_word(input sro_pkg::sro_opt5_t s);
        logic [31:0] w;
        w = '0;
        w[sro_pkg::P2_ODE_BIT]     = s.port2_open_drain_enable;
        w[sro_pkg::P1_ODE_BIT]     = s.port1_open_drain_enable;
        w[sro_pkg::P0_ODE_BIT]     = s.port0_open_drain_enable;
        w[sro_pkg::P1_RX_BIT]      = s.port1_receive_source;
        w[sro_pkg::P1_TX_LSB +: 2] = s.port1_transmit_source;
        w[sro_pkg::P0_RX_BIT]      = s.port0_receive_source;
        w[sro_pkg::P0_TX_LSB +: 2] = s.port0_transmit_source;
        return w;
    endfunction : opt5_to_word

    function automatic sro_pkg::sro_opt5_t word_to_opt5(input logic [31:0] w);
        sro_pkg::sro_opt5_t s;
        s.port2_open_drain_enable = w[sro_pkg::P2_ODE_BIT];
        s.port1_open_drain_enable = w[sro_pkg::P1_ODE_BIT];
        s.port0_open_drain_enable = w[sro_pkg::P0_ODE_BIT];
        s.port1_receive_source    = w[sro_pkg::P1_RX_BIT];
        s.port1_transmit_source   = sro_pkg::sro_tx_src_t'(w[sro_pkg::P1_TX_LSB +: 2]);
        s.port0_receive_source    = w[sro_pkg::P0_RX_BIT];
        s.port0_transmit_source   = sro_pkg::sro_tx_src_t'(w[sro_pkg::P0_TX_LSB +: 2]);
        return s;
    endfunction : word_to_opt5

    function automatic logic [31:0] opt7_to_word(input sro_pkg::sro_opt7_t s);
        logic [31:0] w;
        w = '0;
        w[sro_pkg::ALT_EN_BIT]                         = s.converter_alt_trigger_enable;
        w[sro_pkg::PRE_SEL_BIT]                        = s.converter_pretrigger_select;
        w[sro_pkg::TRG_SEL_LSB +: sro_pkg::TRG_SEL_W]  = s.converter_trigger_select;
        return w;
    endfunction : opt7_to_word

    function automatic sro_pkg::sro_opt7_t word_to_opt7(input logic [31:0] w);
        sro_pkg::sro_opt7_t s;
        s.converter_alt_trigger_enable = w[sro_pkg::ALT_EN_BIT];
        s.converter_pretrigger_select  = w[sro_pkg::PRE_SEL_BIT];
        s.converter_trigger_select     = w[sro_pkg::TRG_SEL_LSB +: sro_pkg::TRG_SEL_W];
        return s;
    endfunction : word_to_opt7

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wdata,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[8*i +: 8] = wdata[8*i +: 8];
            end
        end
        return r;
    endfunction : merge_strb

    // Register next state; read data and error are latched in the setup phase
    always_comb
    begin
        opt5_d    = opt5_q;
        opt7_d    = opt7_q;
        prdata_d  = prdata_q;
        pslverr_d = pslverr_q;
        if (setup)
        begin
            pslverr_d = !(hit5 || hit7);
            if (apb_req.pwrite)
            begin
                prdata_d = '0;
            end
            else if (hit5)
            begin
                prdata_d = opt5_to_word(opt5_q);
            end
            else if (hit7)
            begin
                prdata_d = opt7_to_word(opt7_q);
            end
            else
            begin
                prdata_d = '0;
            end
        end
        if (access && apb_req.pwrite && hit5)
        begin
            // Only defined fields are extracted, reserved bits drop out
            opt5_d = word_to_opt5(merge_strb(opt5_to_word(opt5_q),
                                             apb_req.pwdata, apb_req.pstrb));
        end
        if (access && apb_req.pwrite && hit7)
        begin
            opt7_d = word_to_opt7(merge_strb(opt7_to_word(opt7_q),
                                             apb_req.pwdata, apb_req.pstrb));
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            opt5_q    <= sro_pkg::OPT5_RESET;
            opt7_q    <= sro_pkg::OPT7_RESET;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            opt5_q    <= opt5_d;
            opt7_q    <= opt7_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Zero-wait slave
    always_comb
    begin
        apb_rsp.prdata  = prdata_q;
        apb_rsp.pready  = 1'b1;
        apb_rsp.pslverr = pslverr_q;
    end

    // Open-drain enables straight from the register
    assign port2_open_drain_enable = opt5_q.port2_open_drain_enable;
    assign port1_open_drain_enable = opt5_q.port1_open_drain_enable;
    assign port0_open_drain_enable = opt5_q.port0_open_drain_enable;

    // Receive source muxes
    always_comb
    begin
        port1_rx_data = opt5_q.port1_receive_source ? analog_comparator_0_out : port1_rx_pin;
        port0_rx_data = opt5_q.port0_receive_source ? analog_comparator_0_out : port0_rx_pin;
    end

    sro_tx_mux u_tx0 (
        .clock       (clock),
        .arst_n      (arst_n),
        .sel         (opt5_q.port0_transmit_source),
        .tx_in       (port0_tx_data),
        .timer_1_ch0 (timer_1_ch0),
        .timer_2_ch0 (timer_2_ch0),
        .tx_out      (port0_tx_pin)
    );

    sro_tx_mux u_tx1 (
        .clock       (clock),
        .arst_n      (arst_n),
        .sel         (opt5_q.port1_transmit_source),
        .tx_in       (port1_tx_data),
        .timer_1_ch0 (timer_1_ch0),
        .timer_2_ch0 (timer_2_ch0),
        .tx_out      (port1_tx_pin)
    );

    sro_trig_mux u_trig (
        .clock       (clock),
        .arst_n      (arst_n),
        .opt         (opt7_q),
        .src         (trig_src),
        .timer_1_ch0 (timer_1_ch0),
        .timer_1_ch1 (timer_1_ch1),
        .conv_trig_a (conv_trig_a),
        .conv_trig_b (conv_trig_b)
    );

    // Bus steps used by the checks below
    sequence opt5_write_s(int unsigned bit_lane);
        access && apb_req.pwrite && hit5 && apb_req.pstrb[bit_lane];
    endsequence

    sequence opt5_read_s;
        setup && !apb_req.pwrite && hit5 ##1 access;
    endsequence

    sequence opt7_read_s;
        setup && !apb_req.pwrite && hit7 ##1 access;
    endsequence

    rsvd5_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        opt5_read_s |-> ((apb_rsp.prdata & ~sro_pkg::OPT5_WR_MASK) == 32'h0000_0000))
        else $error("reserved bits of serial option register not zero");

    rsvd7_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        opt7_read_s |-> ((apb_rsp.prdata & ~sro_pkg::OPT7_WR_MASK) == 32'h0000_0000))
        else $error("reserved bits of trigger option register not zero");

    opt7_readback_a: assert property (@(posedge clock) disable iff (!arst_n)
        (access && apb_req.pwrite && hit7 && (&apb_req.pstrb)) ##1 opt7_read_s
        |-> (apb_rsp.prdata == ($past(apb_req.pwdata, 3) & sro_pkg::OPT7_WR_MASK)))
        else $error("trigger option readback does not match masked write");

    opt5_readback_a: assert property (@(posedge clock) disable iff (!arst_n)
        (access && apb_req.pwrite && hit5 && (&apb_req.pstrb)) ##1 opt5_read_s
        |-> (apb_rsp.prdata == ($past(apb_req.pwdata, 2) & sro_pkg::OPT5_WR_MASK)))
        else $error("serial option readback does not match masked write");

    p2_ode_a: assert property (@(posedge clock) disable iff (!arst_n)
        opt5_write_s(2) |=> (port2_open_drain_enable == $past(apb_req.pwdata[sro_pkg::P2_ODE_BIT])))
        else $error("port 2 open-drain enable not updated");

    p1_ode_a: assert property (@(posedge clock) disable iff (!arst_n)
        opt5_write_s(2) |=> (port1_open_drain_enable == $past(apb_req.pwdata[sro_pkg::P1_ODE_BIT])))
        else $error("port 1 open-drain enable not updated");

    p0_ode_a: assert property (@(posedge clock) disable iff (!arst_n)
        opt5_write_s(2) |=> (port0_open_drain_enable == $past(apb_req.pwdata[sro_pkg::P0_ODE_BIT])))
        else $error("port 0 open-drain enable not updated");

    p1_rx_src_a: assert property (@(posedge clock) disable iff (!arst_n)
        opt5_write_s(0) ##1 1'b1
        |-> (port1_rx_data == ($past(apb_req.pwdata[sro_pkg::P1_RX_BIT]) ? analog_comparator_0_out
                                                                          : port1_rx_pin)))
        else $error("port 1 receive source wrong after write");

    p0_rx_src_a: assert property (@(posedge clock) disable iff (!arst_n)
        opt5_write_s(0) ##1 1'b1
        |-> (port0_rx_data == ($past(apb_req.pwdata[sro_pkg::P0_RX_BIT]) ? analog_comparator_0_out
                                                                          : port0_rx_pin)))
        else $error("port 0 receive source wrong after write");

    p0_tx_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        (!(access && apb_req.pwrite && hit5)) |=> $stable(opt5_q.port0_transmit_source))
        else $error("port 0 transmit source changed without write");

    trig_keep_a: assert property (@(posedge clock) disable iff (!arst_n)
        (!(access && apb_req.pwrite && hit7) && opt7_q.converter_alt_trigger_enable
         && opt7_q.converter_trigger_select == sro_pkg::TRG_PIT0) |=> (conv_trig_a || conv_trig_b) == trig_src.pit0)
        else $error("alternate trigger routing lost");

    unmapped_err_a: assert property (@(posedge clock) disable iff (!arst_n)
        (setup && !hit5 && !hit7) |=> (access |-> (apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)))
        else $error("unmapped access not flagged");

endmodule : sro_top

/* dv/sro_periph_model.sv */
// Model of the peripherals that feed the routing bank: pins, timers, comparator and trigger sources.
// Assumes the bench seeds the generator; all levels change just after each rising edge.
`timescale 1ns/100ps
module sro_periph_model (
    // Clock
    input  wire logic              clock,
    // Serial port pins and data
    output logic                   port0_rx_pin,
    output logic                   port1_rx_pin,
    output logic                   port0_tx_data,
    output logic                   port1_tx_data,
    // Timer and comparator outputs
    output logic                   timer_1_ch0,
    output logic                   timer_1_ch1,
    output logic                   timer_2_ch0,
    output logic                   analog_comparator_0_out,
    // Alternate trigger sources
    output sro_pkg::sro_trig_src_t trig_src
);
    logic [17:0] lv = '0;
    assign {port0_rx_pin, port1_rx_pin, port0_tx_data, port1_tx_data, timer_1_ch0, timer_1_ch1,
            timer_2_ch0, analog_comparator_0_out, trig_src} = lv;
    // Fresh levels each cycle so a stuck or registered mux leg shows up
    always @(posedge clock)
    begin
        lv <= 18'($urandom);
    end
endmodule : sro_periph_model

/* dv/tb.sv */
// Self-checking bench for the routing option bank: APB master, shadow registers, mux checks.
// Assumes the peripheral model drives all routing sources.
`timescale 1ns/100ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin num_errors++; $display("MISMATCH %0t %s", $time, m); end end
module tb;
    logic                   clock = 1'b0;
    logic                   arst_n = 1'b0;
    sro_pkg::sro_apb_req_t  apb_req = '0;
    sro_pkg::sro_apb_rsp_t  apb_rsp;
    sro_pkg::sro_trig_src_t trig_src;
    logic port0_open_drain_enable, port1_open_drain_enable, port2_open_drain_enable;
    logic port0_rx_pin, port1_rx_pin, port0_rx_data, port1_rx_data, port0_tx_data, port1_tx_data;
    logic port0_tx_pin, port1_tx_pin, timer_1_ch0, timer_1_ch1, timer_2_ch0, analog_comparator_0_out;
    logic conv_trig_a, conv_trig_b;
    logic [31:0] s5 = '0, s7 = '0, w5, w7;
    logic [32:0] exp_q[$];
    int          num_errors = 0, check_count = 0;
    always #10 clock = ~clock;
    sro_top i_dut (.clock, .arst_n, .apb_req, .apb_rsp, .port0_open_drain_enable, .port1_open_drain_enable,
        .port2_open_drain_enable, .port0_rx_pin, .port1_rx_pin, .port0_rx_data, .port1_rx_data, .port0_tx_data,
        .port1_tx_data, .port0_tx_pin, .port1_tx_pin, .timer_1_ch0, .timer_1_ch1, .timer_2_ch0,
        .analog_comparator_0_out, .trig_src, .conv_trig_a, .conv_trig_b);
    sro_periph_model i_periph (.clock, .port0_rx_pin, .port1_rx_pin, .port0_tx_data, .port1_tx_data,
        .timer_1_ch0, .timer_1_ch1, .timer_2_ch0, .analog_comparator_0_out, .trig_src);
    function automatic logic txf(input logic [1:0] c, input logic d);
        return (c == 2'h1) ? (d & timer_1_ch0) : (c == 2'h2) ? (d & timer_2_ch0) : d;
    endfunction : txf
    function automatic logic trg(input logic [3:0] c);
        case (c)
            4'h0: return trig_src.ext;
            4'h1: return trig_src.analog_comparator_0;
            4'h4: return trig_src.pit0;
            4'h5: return trig_src.pit1;
            4'h8: return trig_src.tmr0_ovf;
            4'h9: return trig_src.tmr1_ovf;
            4'hA: return trig_src.tmr2_ovf;
            4'hC: return trig_src.rtc_alarm;
            4'hD: return trig_src.rtc_seconds;
            4'hE: return trig_src.lptmr;
            default: return 1'b0;
        endcase
    endfunction : trg
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    // One transfer; leaves psel high so a back-to-back setup may follow
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] m;
        logic [31:0] rd;
        int          n;
        m = '0;
        rd = (a == sro_pkg::OPT5_OFFSET) ? s5 : (a == sro_pkg::OPT7_OFFSET) ? s7 : 32'h0;
        n = 0;
        for (int i = 0; i < 4; i++)
            m[8*i +: 8] = {8{st[i]}};
        exp_q.push_back({a != sro_pkg::OPT5_OFFSET && a != sro_pkg::OPT7_OFFSET, wr ? 32'h0 : rd});
        apb_req <= '{1'b1, 1'b0, wr, a, d, st};
        @(posedge clock);
        apb_req.penable <= 1'b1;
        do
            @(posedge clock);
        while (apb_rsp.pready !== 1'b1 && n++ < 20);
        if (n > 20)
            num_errors++;
        if (wr && a == sro_pkg::OPT5_OFFSET)
            s5 = ((s5 & ~m) | (d & m)) & sro_pkg::OPT5_WR_MASK;
        if (wr && a == sro_pkg::OPT7_OFFSET)
            s7 = ((s7 & ~m) | (d & m)) & sro_pkg::OPT7_WR_MASK;
    endtask : apb
    task automatic idle();
        apb_req <= '0;
        @(posedge clock);
    endtask : idle
    task automatic check_routes();
        logic sel;
        @(negedge clock);
        sel = trg(s7[3:0]);
        `CHK({port2_open_drain_enable, port1_open_drain_enable, port0_open_drain_enable}, s5[18:16], "ode")
        `CHK(port1_rx_data, s5[6] ? analog_comparator_0_out : port1_rx_pin, "rx1")
        `CHK(port1_tx_pin, txf(s5[5:4], port1_tx_data), "tx1")
        `CHK(port0_rx_data, s5[2] ? analog_comparator_0_out : port0_rx_pin, "rx0")
        `CHK(port0_tx_pin, txf(s5[1:0], port0_tx_data), "tx0")
        `CHK({conv_trig_a, conv_trig_b}, s7[7] ? {!s7[4] & sel, s7[4] & sel} : {timer_1_ch0, timer_1_ch1}, "trg")
        @(posedge clock);
    endtask : check_routes
    // Watches each completed transfer against the oldest note
    always @(posedge clock)
    begin
        if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1)
            `CHK({apb_rsp.pslverr, apb_rsp.prdata}, exp_q.pop_front(), "apb")
    end
    initial
    begin
        #(20 * 20000);
        num_errors++;
        complete_run();
    end
    initial
    begin
        void'($urandom(32'h8AB0));
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        apb(1'b0, sro_pkg::OPT5_OFFSET, 32'h0, 4'hF);
        apb(1'b0, sro_pkg::OPT7_OFFSET, 32'h0, 4'hF);
        apb(1'b1, sro_pkg::OPT5_OFFSET, 32'hFFFF_FFFF, 4'hF);
        apb(1'b1, sro_pkg::OPT7_OFFSET, 32'hFFFF_FFFF, 4'hF);
        apb(1'b1, 16'h1014, 32'h0, 4'hF);
        apb(1'b0, 16'h1014, 32'h0, 4'hF);
        apb(1'b0, sro_pkg::OPT5_OFFSET, 32'h0, 4'hF);
        apb(1'b0, sro_pkg::OPT7_OFFSET, 32'h0, 4'hF);
        idle();
        check_routes();
        apb(1'b1, sro_pkg::OPT5_OFFSET, 32'h0, 4'h4);
        apb(1'b0, sro_pkg::OPT5_OFFSET, 32'h0, 4'hF);
        idle();
        check_routes();
        for (int i = 0; i < 64; i++)
        begin
            w5 = ($urandom & ~32'h33) | {26'h0, i[3:2], 2'h0, i[1:0]};
            w7 = ($urandom & ~32'h9F) | {24'h0, i >= 16, 2'h0, i[5], i[3:0]};
            apb(1'b1, sro_pkg::OPT5_OFFSET, w5, 4'hF);
            apb(1'b0, sro_pkg::OPT5_OFFSET, 32'h0, 4'hF);
            apb(1'b1, sro_pkg::OPT7_OFFSET, w7, 4'hF);
            apb(1'b0, sro_pkg::OPT7_OFFSET, 32'h0, 4'hF);
            idle();
            repeat (3) check_routes();
        end
        complete_run();
    end
endmodule : tb
